// ===== pbg_pkg.sv
package pbg_pkg;
  // clock and time base
  localparam int CLK_NS = 40;
  localparam int MS_NS = 1_000_000;
  localparam int MS_CYCLES = MS_NS / CLK_NS;
  localparam int DEB_NS = 640;
  localparam int DEB_CYCLES = (DEB_NS + CLK_NS - 1) / CLK_NS;
  localparam int DEB_W = $clog2(DEB_CYCLES + 1);
  // timer figures in milliseconds
  localparam int SHORT_MIN_MS = 60;
  localparam int LONG_MS = 2000;
  localparam int DISP_MS = 4000;
  localparam int IDLE_MS = 16000;
  localparam int CHG_PER_MS = 1000;
  localparam int CHG_ON_MS = 500;
  localparam int WARN_PER_MS = 250;
  localparam int WARN_ON_MS = 125;
  localparam int BCN_PER_MS = 2000;
  localparam int BCN_ON_MS = 250;
  // battery comparator bank, one bit per threshold, high when above
  localparam int BT_N = 12;
  localparam int BT_2V9 = 0;
  localparam int BT_3V1 = 1;
  localparam int BT_3V2 = 2;
  localparam int BT_3V43 = 3;
  localparam int BT_3V55 = 4;
  localparam int BT_3V71 = 5;
  localparam int BT_3V72 = 6;
  localparam int BT_3V85 = 7;
  localparam int BT_3V87 = 8;
  localparam int BT_4V02 = 9;
  localparam int BT_4V07 = 10;
  localparam int BT_4V2 = 11;
  // other synchronised inputs, placed above the battery bank
  localparam int IN_VIN_OK = 12;
  localparam int IN_VIN_SEEN = 13;
  localparam int IN_CHG_END = 14;
  localparam int IN_LOAD = 15;
  localparam int IN_LOAD_IDLE = 16;
  localparam int IN_DIE_HOT = 17;
  localparam int IN_NTC_GND = 18;
  localparam int IN_NTC_FAULT = 19;
  localparam int IN_KEY_N = 20;
  localparam int IN_N = 21;
  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_BATT = 8'h08;
  localparam int CTRL_NTC_IGN_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam logic CTRL_NTC_IGN_RST = 1'h0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_TORCH_BIT = 4;
  localparam int STAT_GATE_BIT = 5;
  localparam int STAT_DISP_BIT = 6;
  localparam int STAT_LED_LSB = 8;
  typedef enum logic [3:0] {
    ST_OFF, ST_BOOST, ST_CHG_SLEEP, ST_TRICKLE, ST_CC, ST_CV, ST_DONE, ST_HOT
  } pbg_state_t;
endpackage

// ===== pbg_ctrl.sv
`timescale 1ns/1ns
// Functional notes
// - charge blink LED chosen by battery voltage
// - charge blink 1 Hz, half second lit
// - end current stops charge, all LEDs lit
// - boost display lights one to four LEDs
// - low battery 4 Hz warning, below 3.2 off
// - display 4 s then slow first-LED beacon
// - charger input under lockout means sleep
// - input above lockout starts charging and blinking
// - below 2.9 V trickle at quarter current
// - above trickle threshold constant current
// - near 4.2 V switch to constant voltage
// - after end, recharge at 4.07 V
// - charging: no boost, short ignored, long torch
// - from off, press or load starts boost
// - path gate high only in normal operation
// - input seen during boost: gate low, charge
// - after charge or overheat, no boost restart without new press
// - light load for 16 s ends boost
// - die overheat cuts boost or charge
// - grounded thermistor disables battery temp check
// - short press 60 ms to 2 s, long beyond
// - under 3.1 V no torch or boost on
module pbg_ctrl #(
  parameter int MS_TICKS = pbg_pkg::MS_CYCLES,
  parameter int IDLE_LIMIT_MS = pbg_pkg::IDLE_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [pbg_pkg::BT_N-1:0] batt_thresh_cmp,
  input wire logic charger_input_supply_ok,
  input wire logic charger_input_supply_seen,
  input wire logic charge_current_end,
  input wire logic load_attached,
  input wire logic load_below_idle,
  input wire logic die_overtemp,
  input wire logic thermistor_sense_grounded,
  input wire logic thermistor_sense_fault,
  input wire logic key_n,
  output logic boost_en,
  output logic power_path_gate,
  output logic charge_en,
  output logic charge_trickle,
  output logic charge_const_v,
  output logic torch_en,
  output logic [3:0] gauge_led_bar
);
  import pbg_pkg::*;

  // every flop of the block lives in this one struct, so reset and
  // registering stay in one place
  // and no field can be left out of either
  typedef struct packed {
    pbg_state_t st;
    logic [IN_N-1:0] sync1;
    logic [IN_N-1:0] sync2;
    logic [IN_N-1:0][DEB_W-1:0] deb;
    logic [IN_N-1:0] clean;
    logic [15:0] pre;
    logic [11:0] key_ms;
    logic long_done;
    logic [11:0] disp_ms;
    logic disp_on;
    logic [10:0] flash;
    logic [15:0] idle_ms;
    logic need_press;
    logic torch;
    logic ntc_ign;
    logic sw_start;
    logic [3:0] leds;
    logic [31:0] rdata;
    logic perr;
  } pbg_regs_t;

  // s_r is the flop copy, s_nxt its next value
  pbg_regs_t s_r;
  pbg_regs_t s_nxt;

  // per-cycle decodes, all written in the pass before they are used
  logic [IN_N-1:0] raw;
  logic [BT_N-1:0] bt;
  logic tick;
  logic pressed;
  logic short_p;
  logic long_p;
  logic press_any;
  logic temp_bad;
  logic charging;
  logic chg_blink;
  logic warn_blink;
  logic bcn_blink;
  logic [1:0] lvl;
  logic idle_hit;
  logic setup;
  logic wr;

  // pin inputs gathered into one vector for the synchroniser
  // the order must match the IN_ and BT_ indices of the package
  assign raw = {key_n, thermistor_sense_fault, thermistor_sense_grounded,
                die_overtemp, load_below_idle, load_attached,
                charge_current_end, charger_input_supply_seen,
                charger_input_supply_ok, batt_thresh_cmp};

  // next state of the whole block
  // one combinational pass computes every field; defaults hold state
  always_comb begin
    s_nxt = s_r;
    // two flops, then a stability counter per input
    // a level must hold 16 clocks before it is believed; comparator
    // glitches are lost, at the cost of about 19 clocks of delay
    s_nxt.sync1 = raw;
    s_nxt.sync2 = s_r.sync1;
    for (int i = 0; i < IN_N; i++) begin
      if (s_r.sync2[i] == s_r.clean[i]) begin
        s_nxt.deb[i] = '0;
      end else if (s_r.deb[i] == DEB_W'(DEB_CYCLES - 1)) begin
        s_nxt.deb[i] = '0;
        s_nxt.clean[i] = s_r.sync2[i];
      end else begin
        s_nxt.deb[i] = s_r.deb[i] + DEB_W'(1);
      end
    end
    bt = s_r.clean[BT_N-1:0];

    // millisecond tick shared by every timer
    // one prescaler keeps all timers in step; MS_TICKS can be cut for
    // simulation, the patterns then run faster but keep their ratios
    // the default is 25000 clocks for a 25 MHz pclk
    tick = (s_r.pre == 16'(MS_TICKS - 1));
    s_nxt.pre = tick ? '0 : s_r.pre + 16'h0001;

    // press classification, measured in ms while held
    // the count saturates at the long limit, so a long hold fires once
    // and its release is not taken as a short press as well
    pressed = !s_r.clean[IN_KEY_N];
    short_p = 1'b0;
    long_p = 1'b0;
    if (pressed) begin
      if (tick && s_r.key_ms != 12'(LONG_MS)) begin
        s_nxt.key_ms = s_r.key_ms + 12'h001;
      end
      if (s_r.key_ms == 12'(LONG_MS) && !s_r.long_done) begin
        long_p = 1'b1;
        s_nxt.long_done = 1'b1;
      end
    end else begin
      short_p = (s_r.key_ms > 12'(SHORT_MIN_MS)) && !s_r.long_done;
      s_nxt.key_ms = '0;
      s_nxt.long_done = 1'b0;
    end
    // a software start request behaves like a short press
    // it is refused by the same rules, so software gains no extra path
    press_any = short_p || s_r.sw_start;

    // free running flash phase, period covers every pattern
    // 2000 ms is a multiple of the 1000 ms and 250 ms periods, so one
    // counter serves all three blink patterns without a jump at wrap
    if (tick) begin
      s_nxt.flash = (s_r.flash == 11'(BCN_PER_MS - 1)) ? '0 : s_r.flash + 11'h001;
    end
    chg_blink = (s_r.flash % 11'(CHG_PER_MS)) < 11'(CHG_ON_MS);
    warn_blink = (s_r.flash % 11'(WARN_PER_MS)) < 11'(WARN_ON_MS);
    bcn_blink = s_r.flash < 11'(BCN_ON_MS);

    // battery temperature is ignored when the sense pin is grounded
    // a fault only masks charge_en; the charge state is kept so that
    // charging resumes where it stopped once the cell is back in window
    temp_bad = s_r.clean[IN_NTC_FAULT] && !s_r.clean[IN_NTC_GND] && !s_r.ntc_ign;

    // torch toggles on a long press in any mode but overheat
    // the low-battery check guards switching on only; a lit torch stays
    // overheat blocks the key so the die is not loaded further
    if (long_p && s_r.st != ST_HOT) begin
      if (s_r.torch) begin
        s_nxt.torch = 1'b0; // a lit torch is never forced off by low battery
      end else if (bt[BT_3V1]) begin
        s_nxt.torch = 1'b1;
      end
    end

    // display window of the boost gauge
    // restarted by each press in boost; cleared whenever boost is left
    if (s_r.disp_on && tick) begin
      if (s_r.disp_ms == 12'(DISP_MS - 1)) begin
        s_nxt.disp_on = 1'b0;
      end else begin
        s_nxt.disp_ms = s_r.disp_ms + 12'h001;
      end
    end

    // light-load timer, only counts inside boost
    // any load above the idle level restarts the count from zero
    // the limit is a parameter so short runs need not wait 16 s
    idle_hit = (s_r.idle_ms == 16'(IDLE_LIMIT_MS));
    if (s_r.st != ST_BOOST || !s_r.clean[IN_LOAD_IDLE]) begin
      s_nxt.idle_ms = '0;
    end else if (tick && !idle_hit) begin
      s_nxt.idle_ms = s_r.idle_ms + 16'h0001;
    end

    // mode sequencing
    // charger presence is tested before presses and loads, so an input
    // that appears together with a press always wins and boost stays off
    unique case (s_r.st)
      // standby: the charger comes first, then a press, then a load
      ST_OFF: begin
        if (s_r.clean[IN_VIN_OK]) begin
          s_nxt.st = bt[BT_2V9] ? ST_CC : ST_TRICKLE;
        end else if (s_r.clean[IN_VIN_SEEN]) begin
          s_nxt.st = ST_CHG_SLEEP;
        end else if (press_any && bt[BT_3V1]) begin
          s_nxt.st = ST_BOOST;
          s_nxt.disp_on = 1'b1;
          s_nxt.disp_ms = '0;
          s_nxt.need_press = 1'b0;
        end else if (s_r.clean[IN_LOAD] && !s_r.need_press && bt[BT_3V1]) begin
          s_nxt.st = ST_BOOST; // load start stays blocked after unplug
        end
      end
      // a charger ends boost at once, before any voltage or idle test
      ST_BOOST: begin
        if (s_r.clean[IN_VIN_SEEN]) begin
          s_nxt.st = ST_CHG_SLEEP; // gate drops with the state
        end else if (!bt[BT_3V2] || idle_hit) begin
          s_nxt.st = ST_OFF;
        end else if (press_any) begin
          s_nxt.disp_on = 1'b1; // replay the gauge, boost untouched
          s_nxt.disp_ms = '0;
        end
      end
      // input present but under lockout: no charge, no boost, leds dark
      ST_CHG_SLEEP: begin
        if (!s_r.clean[IN_VIN_SEEN]) begin
          s_nxt.st = ST_OFF;
          s_nxt.need_press = 1'b1;
        end else if (s_r.clean[IN_VIN_OK]) begin
          s_nxt.st = bt[BT_2V9] ? ST_CC : ST_TRICKLE;
        end
      end
      ST_TRICKLE, ST_CC, ST_CV, ST_DONE: begin
        // short presses fall through unused here
        // the phases advance in charge order, one step per clock at most
        if (!s_r.clean[IN_VIN_SEEN]) begin
          s_nxt.st = ST_OFF; // leaving charge goes to standby
          s_nxt.need_press = 1'b1;
        end else if (!s_r.clean[IN_VIN_OK]) begin
          s_nxt.st = ST_CHG_SLEEP;
        end else if (s_r.st == ST_TRICKLE && bt[BT_2V9]) begin
          s_nxt.st = ST_CC;
        end else if (s_r.st == ST_CC && bt[BT_4V2]) begin
          s_nxt.st = ST_CV;
        end else if (s_r.st == ST_CV && s_r.clean[IN_CHG_END]) begin
          s_nxt.st = ST_DONE;
        end else if (s_r.st == ST_DONE && !bt[BT_4V07]) begin
          s_nxt.st = bt[BT_2V9] ? ST_CC : ST_TRICKLE;
        end
      end
      // stays until the die cools; nothing else is heeded here
      ST_HOT: begin
        if (!s_r.clean[IN_DIE_HOT]) begin
          s_nxt.st = ST_OFF;
          s_nxt.need_press = 1'b1;
        end
      end
    endcase
    // overheat wins over every other transition
    // leaving overheat owes a press, so a hot load cannot cycle boost
    if (s_r.clean[IN_DIE_HOT]) begin
      s_nxt.st = ST_HOT;
    end
    if (s_nxt.st != ST_BOOST) begin
      s_nxt.disp_on = 1'b0;
    end

    // gauge pattern, registered so the pins never glitch
    // the pattern trails the state by one clock; harmless at led speed
    // in states without a pattern the bar is dark
    charging = (s_r.st == ST_TRICKLE) || (s_r.st == ST_CC) || (s_r.st == ST_CV);
    lvl = bt[BT_4V02] ? 2'h3 : bt[BT_3V87] ? 2'h2 : bt[BT_3V72] ? 2'h1 : 2'h0;
    s_nxt.leds = 4'h0;
    if (charging) begin
      for (int j = 0; j < 4; j++) begin
        if (j < int'(lvl)) begin
          s_nxt.leds[j] = 1'b1;
        end else if (j == int'(lvl)) begin
          s_nxt.leds[j] = chg_blink;
        end
      end
    end else if (s_r.st == ST_DONE) begin
      s_nxt.leds = 4'hf;
    end else if (s_r.st == ST_BOOST) begin
      if (!s_r.disp_on) begin
        s_nxt.leds = {3'h0, bcn_blink};
      end else if (bt[BT_3V85]) begin
        s_nxt.leds = 4'hf;
      end else if (bt[BT_3V71]) begin
        s_nxt.leds = 4'h7;
      end else if (bt[BT_3V55]) begin
        s_nxt.leds = 4'h3;
      end else if (bt[BT_3V43]) begin
        s_nxt.leds = 4'h1;
      end else begin
        s_nxt.leds = {3'h0, warn_blink};
      end
    end

    // apb slave: zero wait, read data captured in the setup cycle
    // capturing in setup lets pready stay high; the price is that a read
    // shows values one clock old, which no status here cares about
    // unmapped offsets answer with an error and zero data
    setup = psel && !penable;
    wr = psel && penable && pwrite;
    s_nxt.sw_start = 1'b0;
    if (wr && paddr == ADDR_CTRL) begin
      s_nxt.ntc_ign = pwdata[CTRL_NTC_IGN_BIT];
      s_nxt.sw_start = pwdata[CTRL_START_BIT];
    end
    if (setup) begin
      s_nxt.rdata = '0;
      s_nxt.perr = 1'b0;
      case (paddr)
        ADDR_CTRL: s_nxt.rdata[CTRL_NTC_IGN_BIT] = s_r.ntc_ign;
        ADDR_STAT: begin
          s_nxt.rdata[STAT_STATE_LSB +: 4] = 4'(s_r.st);
          s_nxt.rdata[STAT_TORCH_BIT] = s_r.torch;
          s_nxt.rdata[STAT_GATE_BIT] = (s_r.st == ST_BOOST);
          s_nxt.rdata[STAT_DISP_BIT] = s_r.disp_on;
          s_nxt.rdata[STAT_LED_LSB +: 4] = s_r.leds;
        end
        ADDR_BATT: s_nxt.rdata[BT_N-1:0] = bt;
        default: s_nxt.perr = 1'b1;
      endcase
    end
  end

  // single state register; reset clears every field but the key path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      // the key rests released, else leaving reset would look like a press
      s_r.sync1[IN_KEY_N] <= 1'b1;
      s_r.sync2[IN_KEY_N] <= 1'b1;
      s_r.clean[IN_KEY_N] <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // outputs decoded from registered state
  // the path gate follows boost alone, so it drops in the same clock
  // that a charger, a flat cell, idle or overheat ends boost
  assign prdata = s_r.rdata;
  assign pready = 1'b1;
  assign pslverr = s_r.perr && psel && penable;
  assign boost_en = (s_r.st == ST_BOOST);
  assign power_path_gate = (s_r.st == ST_BOOST);
  assign charge_en = ((s_r.st == ST_TRICKLE) || (s_r.st == ST_CC) ||
                      (s_r.st == ST_CV)) && !temp_bad;
  assign charge_trickle = (s_r.st == ST_TRICKLE);
  assign charge_const_v = (s_r.st == ST_CV);
  assign torch_en = s_r.torch;
  assign gauge_led_bar = s_r.leds;
endmodule // pbg_ctrl

// ===== pbg_ctrl_props.sv
`timescale 1ns/1ns
module pbg_ctrl_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [pbg_pkg::BT_N-1:0] batt_thresh_cmp,
  input wire logic charger_input_supply_ok,
  input wire logic charger_input_supply_seen,
  input wire logic die_overtemp,
  input wire logic boost_en,
  input wire logic power_path_gate,
  input wire logic charge_en,
  input wire logic charge_trickle,
  input wire logic charge_const_v,
  input wire logic torch_en,
  input wire logic [3:0] gauge_led_bar
);
  import pbg_pkg::*;
  // raw input hold counts; 30 clocks outlast sync, debounce and the state step
  logic [3:0][5:0] held;
  wire logic [3:0] cond = {die_overtemp, charger_input_supply_seen,
    !charger_input_supply_ok, !batt_thresh_cmp[BT_3V1]};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        held[i] <= !cond[i] ? 6'h00 : (held[i] == 6'h3f) ? held[i] : held[i] + 6'h01;
      end
    end
  end
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_cc_reaches_top;
    charge_en && !charge_trickle && !charge_const_v && $rose(batt_thresh_cmp[BT_4V2]);
  endsequence
  // a falling voltage phase with no charging and no heat can only be the end state
  sequence s_done_entry;
    $fell(charge_const_v) && !charge_en && charger_input_supply_ok && !die_overtemp;
  endsequence
  a_gate_is_boost: assert property (power_path_gate == boost_en)
    else $error("path gate and boost enable differ");
  a_charge_no_boost: assert property (charge_en |-> !boost_en)
    else $error("boost on while charging");
  a_hot_cuts_all: assert property (held[3] >= 6'h1e |-> !boost_en && !charge_en)
    else $error("boost or charge on while overheated");
  a_charger_drops_gate: assert property (held[2] >= 6'h1e |-> !power_path_gate)
    else $error("path gate high with charger present");
  a_lockout_no_charge: assert property (held[1] >= 6'h1e |-> !charge_en)
    else $error("charging below input lockout");
  a_trickle_exit: assert property ($rose(batt_thresh_cmp[BT_2V9]) && charge_trickle
    |-> ##[1:30] !charge_trickle) else $error("trickle kept above threshold");
  a_cv_entry: assert property (s_cc_reaches_top |-> ##[1:30] charge_const_v)
    else $error("no constant voltage phase near full");
  a_low_batt_start: assert property (held[0] >= 6'h1e
    |-> !$rose(boost_en) && !$rose(torch_en)) else $error("start on a flat battery");
  a_done_all_lit: assert property (s_done_entry |-> ##[0:3] gauge_led_bar == 4'hf)
    else $error("end of charge without full bar");
endmodule // pbg_ctrl_props
bind pbg_ctrl pbg_ctrl_props u_pbg_ctrl_props (.*);

// ===== pbg_cell_model.sv
`timescale 1ns/1ns
module pbg_cell_model #(
  parameter int MS_TICKS = 4
) (
  input wire logic pclk,
  input wire logic [12:0] batt_mv,
  output logic [pbg_pkg::BT_N-1:0] batt_thresh_cmp,
  output logic key_n
);
  import pbg_pkg::*;
  // cell thresholds in millivolts, lowest first; a comparator is high above its level
  localparam int THR [BT_N] = '{2900, 3100, 3200, 3430, 3550, 3710,
    3720, 3850, 3870, 4020, 4070, 4200};
  always_comb begin
    for (int i = 0; i < BT_N; i++) begin
      batt_thresh_cmp[i] = int'(batt_mv) > THR[i];
    end
  end
  // key rests high on its pull-up
  initial key_n = 1'b1;
  // the user holds the key; a restart after charging needs such a press
  task automatic hold_key(input int ms);
    @(posedge pclk);
    key_n <= 1'b0;
    repeat (ms * MS_TICKS) @(posedge pclk);
    key_n <= 1'b1;
  endtask
endmodule // pbg_cell_model

// ===== test_pbg_ctrl.sv
`timescale 1ns/1ns
module test_pbg_ctrl;
  import pbg_pkg::*;
  localparam int MT = 4;
  localparam logic [12:0] MVS [4] = '{13'h0f3c, 13'h0ed8, 13'h0e10, 13'h0dac};
  localparam logic [3:0] BAR [4] = '{4'hf, 4'h7, 4'h3, 4'h1};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ok = 1'b0, seen = 1'b0, cend = 1'b0;
  logic load = 1'b0, idle = 1'b0, hot = 1'b0, grnd = 1'b0, flt = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [12:0] mv = 13'h1004;
  logic pready, pslverr, erd, key_n, boost_en, power_path_gate, charge_en;
  logic charge_trickle, charge_const_v, torch_en;
  logic [3:0] gauge_led_bar;
  logic [BT_N-1:0] batt_thresh_cmp;
  int miscompares = 0, n_compared = 0, lit;
  // short timebase: 4 clocks a millisecond, 20 ms light-load limit
  pbg_ctrl #(.MS_TICKS(MT), .IDLE_LIMIT_MS(20)) u_pbg_ctrl (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .batt_thresh_cmp(batt_thresh_cmp),
    .charger_input_supply_ok(ok), .charger_input_supply_seen(seen), .charge_current_end(cend),
    .load_attached(load), .load_below_idle(idle), .die_overtemp(hot),
    .thermistor_sense_grounded(grnd), .thermistor_sense_fault(flt), .key_n(key_n),
    .boost_en(boost_en), .power_path_gate(power_path_gate), .charge_en(charge_en),
    .charge_trickle(charge_trickle), .charge_const_v(charge_const_v), .torch_en(torch_en),
    .gauge_led_bar(gauge_led_bar));
  pbg_cell_model #(.MS_TICKS(MT)) u_pbg_cell_model (.pclk(pclk), .batt_mv(mv),
    .batt_thresh_cmp(batt_thresh_cmp), .key_n(key_n));
  always #20 pclk = ~pclk;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // inputs need about 20 clocks to pass sync and debounce
  task automatic settle;
    wt(30);
  endtask
  task automatic setmv(input logic [12:0] v);
    @(posedge pclk);
    mv <= v;
    settle;
  endtask
  task automatic cnt_lit(input int b, input int n, input int e);
    lit = 0;
    // sampled mid-cycle, away from the edge that updates the bar
    repeat (n) begin
      @(negedge pclk);
      lit += gauge_led_bar[b];
    end
    chk(lit, e);
  endtask
  // one transfer; request held until pready is seen high at an access edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    erd = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic conclude;
    $display("compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // the whole run takes about 44000 clocks
  initial begin
    wt(90000);
    miscompares++;
    conclude;
  end
  initial begin
    wt(4);
    presetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk(erd, 1'b1);
    // short press from off: boost with the level display
    u_pbg_cell_model.hold_key(100);
    settle;
    chk({boost_en, power_path_gate}, 2'b11);
    for (int i = 0; i < 4; i++) begin
      setmv(MVS[i]);
      chk(gauge_led_bar, BAR[i]);
    end
    setmv(13'h0ce4);
    chk(gauge_led_bar[3:1], 3'h0);
    cnt_lit(0, 1000, 500);
    wt(16000);
    chk(gauge_led_bar[3:1], 3'h0);
    cnt_lit(0, 8000, 1000);
    @(posedge pclk);
    idle <= 1'b1;
    wt(150);
    chk(boost_en, 1'b0);
    // a load alone restarts boost while no press is owed, without display
    @(posedge pclk);
    idle <= 1'b0;
    load <= 1'b1;
    settle;
    chk({boost_en, power_path_gate}, 2'b11);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rd[6:0], 7'h21);
    @(posedge pclk);
    idle <= 1'b1;
    load <= 1'b0;
    wt(150);
    chk(boost_en, 1'b0);
    @(posedge pclk);
    idle <= 1'b0;
    setmv(13'h0bb8);
    u_pbg_cell_model.hold_key(100);
    settle;
    chk(boost_en, 1'b0);
    // start request, then the cell sags under 3.2 V
    setmv(13'h0d48);
    apb(1'b1, ADDR_CTRL, 32'h2);
    settle;
    chk(boost_en, 1'b1);
    setmv(13'h0c4e);
    chk(boost_en, 1'b0);
    // charger arrives during boost, below lockout first
    setmv(13'h0e10);
    apb(1'b1, ADDR_CTRL, 32'h2);
    settle;
    @(posedge pclk);
    seen <= 1'b1;
    settle;
    chk({boost_en, power_path_gate}, 2'b00);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rd[3:0], 4'h2);
    setmv(13'h0af0);
    @(posedge pclk);
    ok <= 1'b1;
    settle;
    chk({charge_en, charge_trickle}, 2'b11);
    setmv(13'h0e10);
    chk({charge_en, charge_trickle}, 2'b10);
    cnt_lit(0, 4000, 2000);
    setmv(13'h0ed8);
    chk(gauge_led_bar & 4'hd, 4'h1);
    cnt_lit(1, 4000, 2000);
    u_pbg_cell_model.hold_key(100);
    settle;
    chk({boost_en, charge_en}, 2'b01);
    u_pbg_cell_model.hold_key(2100);
    settle;
    chk({boost_en, torch_en}, 2'b01);
    setmv(13'h109a);
    chk(charge_const_v, 1'b1);
    @(posedge pclk);
    cend <= 1'b1;
    settle;
    chk({charge_en, gauge_led_bar}, 5'h0f);
    @(posedge pclk);
    cend <= 1'b0;
    setmv(13'h0fa0);
    chk(charge_en, 1'b1);
    apb(1'b0, ADDR_BATT, 32'h0);
    chk(rd, 32'h1ff);
    @(posedge pclk);
    flt <= 1'b1;
    grnd <= 1'b1;
    settle;
    chk(charge_en, 1'b1);
    @(posedge pclk);
    grnd <= 1'b0;
    settle;
    chk(charge_en, 1'b0);
    // software can mask the battery temperature check as well
    apb(1'b1, ADDR_CTRL, 32'h1);
    wt(1);
    chk(charge_en, 1'b1);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h0);
    wt(1);
    chk(charge_en, 1'b0);
    @(posedge pclk);
    flt <= 1'b0;
    hot <= 1'b1;
    settle;
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(rd[3:0], 4'h7);
    // charger gone: a load alone must not restart boost
    @(posedge pclk);
    hot <= 1'b0;
    seen <= 1'b0;
    ok <= 1'b0;
    load <= 1'b1;
    settle;
    chk(boost_en, 1'b0);
    u_pbg_cell_model.hold_key(100);
    settle;
    chk(boost_en, 1'b1);
    conclude;
  end
endmodule // test_pbg_ctrl
